//--- logic/itw_defines.svh
// Constants for the serial target and host-mode supervisor
`ifndef ITW_DEFINES_SVH
`define ITW_DEFINES_SVH

// ----------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------
`define ITW_TADDR 7'h6B
`define ITW_REG_LAST 8'h48
`define ITW_RD_UNDEF 8'hFF
`define ITW_BYTE_BITS 4'h8
`define ITW_TX_LAST 4'h7

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define ITW_REG_FORCE 8'h0F
`define ITW_REG_WDCTRL 8'h10
`define ITW_REG_STATUS 8'h1F
`define ITW_REG_FLAG 8'h25
`define ITW_REG_MASK 8'h2B
`define ITW_FRC_ICO 0
`define ITW_FRC_DL 1
`define ITW_FRC_OC 2
`define ITW_WD_PER_HI 1
`define ITW_WD_PER_LO 0
`define ITW_WATCHDOG_RESTART_BIT_BIT 2
`define ITW_REG_RST_BIT 3
`define ITW_MASK_BIT 0
`define ITW_WD_PER_DEF 2'h1
`define ITW_WD_OFF 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ITW_CLK_HZ 64'h5F5E100
`define ITW_SEC_PER_H 64'hE10
`define ITW_TRICKLE_H 64'h1
`define ITW_PRE_H 64'h2
`define ITW_FAST_H 64'hC
`define ITW_WD_P1_S 64'h28
`define ITW_WD_P2_S 64'h50
`define ITW_WD_P3_S 64'hA0
`define ITW_CNT_W 44

`endif

//--- logic/itw_pkg.sv
// Types shared by the serial target and supervisor
package itw_pkg;
`include "itw_defines.svh"

  typedef struct packed {
    logic scl;
    logic sda;
  } itw_pin_t;

  typedef enum logic [2:0] {
    L_IDLE, L_RX, L_ACK, L_WAIT, L_TX, L_TXACK
  } itw_lst_t;

  typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} itw_kind_t;

  typedef enum logic [1:0] {
    PH_NONE, PH_TRICKLE, PH_PRE, PH_FAST
  } itw_phase_t;

  typedef logic [`ITW_REG_LAST:0][7:0] itw_regs_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } itw_xreq_t;

  typedef struct packed {
    itw_lst_t state;
    itw_kind_t kind;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic rw;
    logic [7:0] ptr;
    logic [7:0] tx;
    itw_xreq_t xr;
    logic req;
    logic sda_oe;
    logic scl_oe;
    logic busy;
    logic cp;
    logic sp;
  } itw_link_t;

  typedef struct packed {
    itw_regs_t regs;
    logic ack;
    logic [7:0] rdata;
    logic flag;
    logic alert_n;
    logic fet_start;
    logic oc_start;
    logic adp_prev;
    logic por_done;
  } itw_core_t;

  typedef struct packed {
    logic dflt;
    logic exp;
    logic [`ITW_CNT_W-1:0] cnt;
    itw_phase_t phase;
    logic [`ITW_CNT_W-1:0] tcnt;
    logic stop;
  } itw_wd_t;
endpackage

//--- logic/itw_sync.sv
// Two-stage level synchroniser
`timescale 1ns/1ps
module itw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Destination clock
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//--- logic/itw_wdog.sv
// Host-mode watchdog and charge safety timers
`timescale 1ns/1ps
module itw_wdog
  import itw_pkg::*;
#(
  parameter logic [`ITW_CNT_W-1:0] WD_P1_CYC = '1,
  parameter logic [`ITW_CNT_W-1:0] WD_P2_CYC = '1,
  parameter logic [`ITW_CNT_W-1:0] WD_P3_CYC = '1,
  parameter logic [`ITW_CNT_W-1:0] TRICKLE_CYC = '1,
  parameter logic [`ITW_CNT_W-1:0] PRE_CYC = '1,
  parameter logic [`ITW_CNT_W-1:0] FAST_CYC = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register-side events
  input wire logic wr_any,
  input wire logic restart,
  input wire logic sw_rst,
  input wire logic [1:0] period,
  // Charger phase
  input wire itw_pkg::itw_phase_t phase,
  // Results
  output logic default_mode,
  output logic expire,
  output logic charge_stop
);
  import itw_pkg::*;

  itw_wd_t r, n;
  logic [`ITW_CNT_W-1:0] wd_lim;
  logic [`ITW_CNT_W-1:0] ph_lim;

  always_comb begin
    n = r;
    n.exp = 1'b0;
    unique case (period)
      2'h1: wd_lim = WD_P1_CYC;
      2'h2: wd_lim = WD_P2_CYC;
      default: wd_lim = WD_P3_CYC;
    endcase
    unique case (phase)
      PH_TRICKLE: ph_lim = TRICKLE_CYC;
      PH_PRE: ph_lim = PRE_CYC;
      PH_FAST: ph_lim = FAST_CYC;
      PH_NONE: ph_lim = '1;
    endcase
    // --------------------------------------------------------------
    // Watchdog
    // --------------------------------------------------------------
    if (wr_any || restart || sw_rst) begin
      n.cnt = '0;
      if (wr_any) begin
        n.dflt = 1'b0;
      end
    end else if (!r.dflt && period != `ITW_WD_OFF) begin
      if (r.cnt >= wd_lim - 1'b1) begin
        n.dflt = 1'b1;
        n.exp = 1'b1;
        n.cnt = '0;
      end else begin
        n.cnt = r.cnt + 1'b1;
      end
    end
    // --------------------------------------------------------------
    // Safety timers; a new phase restarts the count
    // --------------------------------------------------------------
    n.phase = phase;
    if (sw_rst || phase != r.phase || phase == PH_NONE) begin
      n.tcnt = '0;
      n.stop = 1'b0;
    end else if (!r.stop) begin
      if (r.tcnt >= ph_lim - 1'b1) begin
        n.stop = 1'b1;
      end else begin
        n.tcnt = r.tcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '{dflt: 1'b1, exp: 1'b0, cnt: '0, phase: PH_NONE,
             tcnt: '0, stop: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign default_mode = r.dflt;
  assign expire = r.exp;
  assign charge_stop = r.stop;
endmodule

//--- logic/itw_top.sv
// Serial register target with host/default mode supervisor
//
// Function
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Bus busy from START until STOP
// - Eight bits, MSB first, then one acknowledge
// - Target may hold clock low when unready
// - Receiver drives data low for acknowledge
// - High data at ninth pulse means NACK
// - First byte: 7-bit address plus direction
// - Answer only address 1101 011
// - Undefined register address gets NACK, idle
// - Pointer advances per byte across registers
// - Reset enters default mode, watchdog expired
// - Default mode sets status, flag, alert
// - Flag reads one once, then zero
// - Safety timers stop charging on expiry
// - Any write enters host mode, starts watchdog
// - Restart bit or period zero keeps host
// - Expiry restores defaults, sets status and flag
// - Write after expiry resets the watchdog
// - Reset request restores defaults, self-clears
// - Software reset skips FET and adapter checks
// - Software reset clears all force requests
// - Data stable while clock high
// - Works at 100 and 400 kbit/s
`timescale 1ns/1ps
module itw_top
  import itw_pkg::*;
#(
  parameter logic [`ITW_CNT_W-1:0] WD_P1_CYC =
    `ITW_CNT_W'(`ITW_WD_P1_S * `ITW_CLK_HZ),
  parameter logic [`ITW_CNT_W-1:0] WD_P2_CYC =
    `ITW_CNT_W'(`ITW_WD_P2_S * `ITW_CLK_HZ),
  parameter logic [`ITW_CNT_W-1:0] WD_P3_CYC =
    `ITW_CNT_W'(`ITW_WD_P3_S * `ITW_CLK_HZ),
  parameter logic [`ITW_CNT_W-1:0] TRICKLE_CYC =
    `ITW_CNT_W'(`ITW_TRICKLE_H * `ITW_SEC_PER_H * `ITW_CLK_HZ),
  parameter logic [`ITW_CNT_W-1:0] PRE_CYC =
    `ITW_CNT_W'(`ITW_PRE_H * `ITW_SEC_PER_H * `ITW_CLK_HZ),
  parameter logic [`ITW_CNT_W-1:0] FAST_CYC =
    `ITW_CNT_W'(`ITW_FAST_H * `ITW_SEC_PER_H * `ITW_CLK_HZ)
) (
  // Device clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link sampling clock
  input wire logic link_clk,
  // Open-drain bus pins
  input wire itw_pkg::itw_pin_t i2c_in,
  output itw_pkg::itw_pin_t i2c_out,
  output itw_pkg::itw_pin_t i2c_oe,
  output logic bus_busy,
  // Charger side
  input wire itw_pkg::itw_phase_t charge_phase,
  input wire logic adapter_present,
  output logic charge_stop,
  output logic fet_detect_start,
  output logic oc_measure_start,
  output logic forced_current_optimise_request,
  output logic forced_dataline_detect_request,
  output logic forced_open_circuit_measure_request,
  // Supervisor status
  output logic watchdog_expired_status,
  output logic host_alert_n
);
  import itw_pkg::*;

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  logic link_rst;
  itw_pin_t pin_s;
  logic ack_s;
  logic req_s;
  logic adp_s;
  itw_link_t lr, ln;
  itw_core_t cr, cn;

  // Reset level carried into the link domain
  itw_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk(link_clk),
    .rst(1'b0),
    .d(reset),
    .q(link_rst)
  );

  // Pins pass two flops before any edge detection
  itw_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk(link_clk),
    .rst(link_rst),
    .d(i2c_in),
    .q(pin_s)
  );

  itw_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk(link_clk),
    .rst(link_rst),
    .d(cr.ack),
    .q(ack_s)
  );

  itw_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk(clk),
    .rst(reset),
    .d(lr.req),
    .q(req_s)
  );

  itw_sync #(.W(1), .RST_VAL(1'b0)) u_adp_sync (
    .clk(clk),
    .rst(reset),
    .d(adapter_present),
    .q(adp_s)
  );

  // ----------------------------------------------------------------
  // Link domain: bit engine
  // ----------------------------------------------------------------
  logic l_start, l_stop, l_rise, l_fall, l_pend;

  // Clock high on both samples: data edge is a condition, not data
  assign l_start = pin_s.scl && lr.cp && lr.sp && !pin_s.sda;
  assign l_stop = pin_s.scl && lr.cp && !lr.sp && pin_s.sda;
  assign l_rise = pin_s.scl && !lr.cp;
  assign l_fall = !pin_s.scl && lr.cp;
  // Request outstanding until the core toggles its answer back
  assign l_pend = lr.req != ack_s;

  function automatic itw_link_t advance(input itw_link_t s,
                                        input logic [7:0] rd);
    itw_link_t t;
    t = s;
    t.bitcnt = '0;
    t.scl_oe = 1'b0;
    if (s.rw) begin
      t.state = L_TX;
      t.tx = rd;
      t.sda_oe = !rd[7];
    end else begin
      t.state = L_RX;
      t.sda_oe = 1'b0;
      t.kind = (s.kind == K_ADDR) ? K_REG : K_DATA;
    end
    return t;
  endfunction

  always_comb begin
    ln = lr;
    ln.cp = pin_s.scl;
    ln.sp = pin_s.sda;
    if (l_start) begin
      ln.state = L_RX;
      ln.kind = K_ADDR;
      ln.bitcnt = '0;
      ln.sda_oe = 1'b0;
      ln.scl_oe = 1'b0;
      ln.busy = 1'b1;
    end else if (l_stop) begin
      ln.state = L_IDLE;
      ln.sda_oe = 1'b0;
      ln.scl_oe = 1'b0;
      ln.busy = 1'b0;
    end else begin
      unique case (lr.state)
        L_IDLE: begin
          ln.sda_oe = 1'b0;
          ln.scl_oe = 1'b0;
        end
        L_RX: begin
          if (l_rise) begin
            // Sampled on the rising edge, stable while high
            ln.sh = {lr.sh[6:0], pin_s.sda};
            ln.bitcnt = lr.bitcnt + 1'b1;
          end else if (l_fall && lr.bitcnt == `ITW_BYTE_BITS) begin
            ln.state = L_ACK;
            ln.sda_oe = 1'b1;
            unique case (lr.kind)
              K_ADDR: begin
                if (lr.sh[7:1] == `ITW_TADDR) begin
                  ln.rw = lr.sh[0];
                  if (lr.sh[0]) begin
                    ln.xr.we = 1'b0;
                    ln.xr.addr = lr.ptr;
                    ln.req = !lr.req;
                  end
                end else begin
                  ln.state = L_IDLE;
                  ln.sda_oe = 1'b0;
                end
              end
              K_REG: begin
                if (lr.sh <= `ITW_REG_LAST) begin
                  ln.ptr = lr.sh;
                end else begin
                  ln.state = L_IDLE;
                  ln.sda_oe = 1'b0;
                end
              end
              K_DATA: begin
                ln.xr.we = 1'b1;
                ln.xr.addr = lr.ptr;
                ln.xr.wdata = lr.sh;
                ln.ptr = lr.ptr + 1'b1;
                ln.req = !lr.req;
              end
              default: ln.state = L_IDLE;
            endcase
          end
        end
        L_ACK: begin
          if (l_fall) begin
            if (l_pend) begin
              ln.state = L_WAIT;
              ln.sda_oe = 1'b0;
              ln.scl_oe = 1'b1;
            end else begin
              ln = advance(ln, cr.rdata);
            end
          end
        end
        L_WAIT: begin
          // Core answers in a few cycles; clock held low meanwhile
          if (!l_pend) begin
            ln = advance(ln, cr.rdata);
          end
        end
        L_TX: begin
          if (l_fall) begin
            if (lr.bitcnt == `ITW_TX_LAST) begin
              ln.sda_oe = 1'b0;
              ln.state = L_TXACK;
            end else begin
              ln.tx = {lr.tx[6:0], 1'b0};
              ln.sda_oe = !lr.tx[6];
              ln.bitcnt = lr.bitcnt + 1'b1;
            end
          end
        end
        L_TXACK: begin
          if (l_rise) begin
            if (pin_s.sda) begin
              ln.state = L_IDLE;
            end else begin
              ln.ptr = lr.ptr + 1'b1;
              ln.xr.we = 1'b0;
              ln.xr.addr = lr.ptr + 1'b1;
              ln.req = !lr.req;
              ln.state = L_ACK;
            end
          end
        end
        default: begin
          ln.state = L_IDLE;
          ln.sda_oe = 1'b0;
          ln.scl_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lr <= '{state: L_IDLE, kind: K_ADDR, sh: '0, bitcnt: '0,
              rw: 1'b0, ptr: '0, tx: '0, xr: '0, req: 1'b0,
              sda_oe: 1'b0, scl_oe: 1'b0, busy: 1'b0,
              cp: 1'b1, sp: 1'b1};
    end else begin
      lr <= ln;
    end
  end

  assign i2c_out = '0;
  assign i2c_oe = '{scl: lr.scl_oe, sda: lr.sda_oe};
  assign bus_busy = lr.busy;

  // ----------------------------------------------------------------
  // Device domain: register file
  // ----------------------------------------------------------------
  logic wr_any, restart, sw_rst, rd_flag, dflt, expire;
  logic [7:0] rd_val;

  function automatic itw_regs_t regs_default();
    itw_regs_t d;
    d = '0;
    d[`ITW_REG_WDCTRL][`ITW_WD_PER_HI:`ITW_WD_PER_LO] = `ITW_WD_PER_DEF;
    return d;
  endfunction

  always_comb begin
    if (lr.xr.addr == `ITW_REG_STATUS) begin
      rd_val = {7'h0, dflt};
    end else if (lr.xr.addr == `ITW_REG_FLAG) begin
      rd_val = {7'h0, cr.flag};
    end else if (lr.xr.addr <= `ITW_REG_LAST) begin
      rd_val = cr.regs[lr.xr.addr];
    end else begin
      rd_val = `ITW_RD_UNDEF;
    end
  end

  always_comb begin
    cn = cr;
    wr_any = 1'b0;
    restart = 1'b0;
    sw_rst = 1'b0;
    rd_flag = 1'b0;
    cn.fet_start = 1'b0;
    // Adapter insertion alone starts the measurement
    cn.adp_prev = adp_s;
    cn.oc_start = adp_s && !cr.adp_prev;
    if (!cr.por_done) begin
      cn.por_done = 1'b1;
      cn.fet_start = 1'b1;
    end
    // Payload held stable by the link while the toggle is pending
    if (req_s != cr.ack) begin
      cn.ack = req_s;
      if (lr.xr.we) begin
        wr_any = 1'b1;
        if (lr.xr.addr == `ITW_REG_WDCTRL) begin
          sw_rst = lr.xr.wdata[`ITW_REG_RST_BIT];
          restart = lr.xr.wdata[`ITW_WATCHDOG_RESTART_BIT_BIT];
          cn.regs[`ITW_REG_WDCTRL] = lr.xr.wdata;
          cn.regs[`ITW_REG_WDCTRL][`ITW_WATCHDOG_RESTART_BIT_BIT] = 1'b0;
        end else if (lr.xr.addr <= `ITW_REG_LAST &&
                     lr.xr.addr != `ITW_REG_STATUS &&
                     lr.xr.addr != `ITW_REG_FLAG) begin
          cn.regs[lr.xr.addr] = lr.xr.wdata;
        end
      end else begin
        cn.rdata = rd_val;
        rd_flag = lr.xr.addr == `ITW_REG_FLAG;
      end
    end
    // Defaults clear force bits, reset request and mask alike
    if (sw_rst || expire) begin
      cn.regs = regs_default();
    end
    // Expiry in the same cycle as a read wins over the clear
    cn.flag = expire || (cr.flag && !rd_flag);
    cn.alert_n = !(dflt && !cn.regs[`ITW_REG_MASK][`ITW_MASK_BIT]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cr <= '{regs: regs_default(), ack: 1'b0, rdata: '0,
              flag: 1'b1, alert_n: 1'b0, fet_start: 1'b0,
              oc_start: 1'b0, adp_prev: 1'b0,
              por_done: 1'b0};
    end else begin
      cr <= cn;
    end
  end

  // ----------------------------------------------------------------
  // Supervisor
  // ----------------------------------------------------------------
  itw_wdog #(
    .WD_P1_CYC(WD_P1_CYC),
    .WD_P2_CYC(WD_P2_CYC),
    .WD_P3_CYC(WD_P3_CYC),
    .TRICKLE_CYC(TRICKLE_CYC),
    .PRE_CYC(PRE_CYC),
    .FAST_CYC(FAST_CYC)
  ) u_wdog (
    .clk(clk),
    .reset(reset),
    .wr_any(wr_any),
    .restart(restart),
    .sw_rst(sw_rst),
    .period(cr.regs[`ITW_REG_WDCTRL][`ITW_WD_PER_HI:`ITW_WD_PER_LO]),
    .phase(charge_phase),
    .default_mode(dflt),
    .expire(expire),
    .charge_stop(charge_stop)
  );

  assign watchdog_expired_status = dflt;
  assign host_alert_n = cr.alert_n;
  assign fet_detect_start = cr.fet_start;
  assign oc_measure_start = cr.oc_start;
  assign forced_current_optimise_request =
    cr.regs[`ITW_REG_FORCE][`ITW_FRC_ICO];
  assign forced_dataline_detect_request =
    cr.regs[`ITW_REG_FORCE][`ITW_FRC_DL];
  assign forced_open_circuit_measure_request =
    cr.regs[`ITW_REG_FORCE][`ITW_FRC_OC];
endmodule

//--- verif/itw_ctl_model.sv
// Bus controller model driving the two open-drain lines
`timescale 1ns/1ps
module itw_ctl_model #(
  parameter int Q = 625
) (
  // Line levels
  input wire logic scl_w,
  input wire logic sda_w,
  // High pulls the line low
  output logic scl_oe,
  output logic sda_oe
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Bounded wait so a clock held low forever cannot hang the run
  task automatic rise();
    scl_oe = 1'b0;
    for (int i = 0; i < 300 && !scl_w; i++) begin
      #10;
    end
  endtask
  task automatic start();
    sda_oe = 1'b0;
    #Q;
    rise();
    #Q;
    sda_oe = 1'b1;
    #Q;
    scl_oe = 1'b1;
    #Q;
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    #Q;
    rise();
    #Q;
    sda_oe = 1'b0;
    #Q;
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_oe = !b;
    #Q;
    rise();
    #Q;
    s = sda_w;
    #Q;
    scl_oe = 1'b1;
    #Q;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic rel,
      output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(rel, a);
    ack = !a;
  endtask
endmodule

//--- verif/itw_chk_assertions.sv
// Port checker for the serial target and supervisor
`timescale 1ns/1ps
module itw_chk (
  // Clocks and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  // Bus pins
  input wire itw_pkg::itw_pin_t i2c_in,
  input wire itw_pkg::itw_pin_t i2c_out,
  input wire itw_pkg::itw_pin_t i2c_oe,
  input wire logic bus_busy,
  // Charger and supervisor
  input wire itw_pkg::itw_phase_t charge_phase,
  input wire logic adapter_present,
  input wire logic charge_stop,
  input wire logic fet_detect_start,
  input wire logic oc_measure_start,
  input wire logic watchdog_expired_status,
  input wire logic host_alert_n
);
  import itw_pkg::*;
  // Never cleared by reset: pair detection is once per power-up
  logic fet_seen_r = 1'b0;
  always_ff @(posedge clk) begin
    if (fet_detect_start) begin
      fet_seen_r <= 1'b1;
    end
  end
  // --------------------------------------------------------------
  // Link domain
  // --------------------------------------------------------------
  a_start_busy: assert property (@(posedge link_clk)
    disable iff (reset) i2c_in.scl && $past(i2c_in.scl) && $fell(i2c_in.sda)
    |-> ##[1:8] bus_busy) else $error("start not seen");
  a_stop_free: assert property (@(posedge link_clk)
    disable iff (reset) i2c_in.scl && $past(i2c_in.scl) && $rose(i2c_in.sda)
    |-> ##[1:8] !bus_busy) else $error("stop not seen");
  a_idle_quiet: assert property (@(posedge link_clk)
    disable iff (reset) !bus_busy && !$past(bus_busy) |-> i2c_oe == '0)
    else $error("pin pulled while bus free");
  a_sda_change: assert property (@(posedge link_clk)
    disable iff (reset) $changed(i2c_oe.sda) |-> !i2c_in.scl)
    else $error("data moved with clock high");
  a_stretch_bound: assert property (@(posedge link_clk)
    disable iff (reset) $rose(i2c_oe.scl) |-> ##[1:60] !i2c_oe.scl)
    else $error("clock held too long");
  a_out_low: assert property (@(posedge link_clk)
    disable iff (reset) i2c_out == '0) else $error("pin driven high");
  // --------------------------------------------------------------
  // Device domain
  // --------------------------------------------------------------
  a_reset_default: assert property (@(posedge clk)
    reset |=> watchdog_expired_status && !host_alert_n)
    else $error("not in default mode at reset");
  a_host_alert: assert property (@(posedge clk)
    disable iff (reset) !watchdog_expired_status &&
    !$past(watchdog_expired_status) |-> host_alert_n)
    else $error("alert in host mode");
  a_fet_once: assert property (@(posedge clk)
    disable iff (reset) fet_detect_start |-> !fet_seen_r)
    else $error("pair detection repeated");
  a_oc_bound: assert property (@(posedge clk)
    disable iff (reset) $rose(adapter_present) |-> ##[1:5] oc_measure_start)
    else $error("no measure on insertion");
  a_stop_phase: assert property (@(posedge clk)
    disable iff (reset) $rose(charge_stop) |-> charge_phase != PH_NONE)
    else $error("stop without a phase");
  c_start: cover property (@(posedge link_clk) $rose(bus_busy));
  c_host: cover property (@(posedge clk) $fell(watchdog_expired_status));
  c_stop: cover property (@(posedge clk) $rose(charge_stop));
endmodule
bind itw_top itw_chk u_chk (.clk, .reset, .link_clk, .i2c_in, .i2c_out,
  .i2c_oe, .bus_busy, .charge_phase, .adapter_present, .charge_stop,
  .fet_detect_start, .oc_measure_start, .watchdog_expired_status,
  .host_alert_n);

//--- verif/tb_itw_top.sv
// Self-checking bench for the serial target and supervisor
`timescale 1ns/1ps
module tb_itw_top;
  import itw_pkg::*;
  typedef struct {
    itw_phase_t ph;
    int cyc;
    logic stop;
  } itw_row_t;
  // Timer rows: phase, cycles held, stop expected
  itw_row_t rows [5] = '{'{PH_TRICKLE, 32'h6E, 1'b1},
    '{PH_PRE, 32'h96, 1'b0}, '{PH_PRE, 32'h50, 1'b1},
    '{PH_FAST, 32'h4C4, 1'b1}, '{PH_NONE, 32'h1E, 1'b0}};
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic adapter_present = 1'b0;
  itw_phase_t charge_phase = PH_NONE;
  itw_pin_t pins;
  itw_pin_t i2c_out;
  itw_pin_t i2c_oe;
  logic scl_m, sda_m, bus_busy, charge_stop, seen;
  logic fet_detect_start, oc_measure_start, watchdog_expired_status;
  logic host_alert_n, frc_ico, frc_dl, frc_oc;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycle_cnt = 0;
  always #5 clk = !clk;
  initial begin
    #7;
    forever #15 link_clk = !link_clk;
  end
  // Pull-ups: a line is low whenever any party pulls it
  assign pins = {!scl_m && (!i2c_oe.scl || i2c_out.scl),
    !sda_m && (!i2c_oe.sda || i2c_out.sda)};
  itw_top #(.WD_P1_CYC(44'hFA0), .WD_P2_CYC(44'h1F40),
    .TRICKLE_CYC(44'h64), .PRE_CYC(44'hC8),
    .FAST_CYC(44'h4B0)) DUT (
    .clk, .reset, .link_clk, .i2c_in(pins), .i2c_out, .i2c_oe, .bus_busy,
    .charge_phase, .adapter_present, .charge_stop, .fet_detect_start,
    .oc_measure_start, .forced_current_optimise_request(frc_ico),
    .forced_dataline_detect_request(frc_dl),
    .forced_open_circuit_measure_request(frc_oc),
    .watchdog_expired_status, .host_alert_n);
  itw_ctl_model ctl (.scl_w(pins.scl), .sda_w(pins.sda),
    .scl_oe(scl_m), .sda_oe(sda_m));
  // --------------------------------------------------------------
  // Checks and bus tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic k_exp);
    logic [7:0] r;
    logic k;
    ctl.byte_io(b, 1'b1, r, k);
    chk(8'(k), 8'(k_exp));
  endtask
  task automatic quit();
    ctl.stop();
    repeat (32'h14) @(negedge clk);
  endtask
  task automatic open_reg(input logic [7:0] a);
    ctl.start();
    send({`ITW_TADDR, 1'b0}, 1'b1);
    send(a, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
    open_reg(a);
    foreach (d[i]) begin
      send(d[i], 1'b1);
    end
    quit();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e [$]);
    logic [7:0] r;
    logic k;
    open_reg(a);
    ctl.start();
    send({`ITW_TADDR, 1'b1}, 1'b1);
    foreach (e[i]) begin
      ctl.byte_io(8'hFF, i == e.size() - 1, r, k);
      chk(r, e[i]);
    end
    quit();
  endtask
  // Limit sits well above the expected run of about 100k cycles
  always @(posedge clk) begin
    cycle_cnt++;
    if (cycle_cnt == 32'h249F0) begin
      n_mismatch++;
      $display("[FAIL] %0t run did not finish", $time);
      final_report();
    end
  end
  initial begin
    repeat (32'hA) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk(8'(watchdog_expired_status), 8'h01);
    chk(8'(host_alert_n), 8'h00);
    foreach (rows[i]) begin
      charge_phase = rows[i].ph;
      repeat (rows[i].cyc) @(negedge clk);
      chk(8'(charge_stop), 8'(rows[i].stop));
    end
    adapter_present = 1'b1;
    seen = 1'b0;
    repeat (32'h8) begin
      @(negedge clk);
      seen = seen | oc_measure_start;
    end
    chk(8'(seen), 8'h01);
    rd(`ITW_REG_FLAG, '{8'h01});
    rd(`ITW_REG_FLAG, '{8'h00});
    chk(8'(watchdog_expired_status), 8'h01);
    wr(`ITW_REG_WDCTRL, '{8'h00});
    chk(8'(watchdog_expired_status), 8'h00);
    chk(8'(host_alert_n), 8'h01);
    ctl.start();
    send({7'h2A, 1'b0}, 1'b0);
    quit();
    ctl.start();
    send({`ITW_TADDR, 1'b0}, 1'b1);
    send(`ITW_REG_LAST + 8'h01, 1'b0);
    quit();
    wr(8'h47, '{8'hA5, 8'h3C});
    rd(8'h47, '{8'hA5, 8'h3C, 8'hFF});
    chk(8'(watchdog_expired_status), 8'h00);
    wr(`ITW_REG_FORCE, '{8'h07});
    chk({5'h00, frc_oc, frc_dl, frc_ico}, 8'h07);
    wr(`ITW_REG_WDCTRL, '{8'h08});
    chk({5'h00, frc_oc, frc_dl, frc_ico}, 8'h00);
    rd(`ITW_REG_WDCTRL, '{8'h01});
    chk(8'(watchdog_expired_status), 8'h01);
    chk(8'(host_alert_n), 8'h00);
    rd(`ITW_REG_FLAG, '{8'h01});
    wr(8'h47, '{8'h11});
    chk(8'(watchdog_expired_status), 8'h00);
    final_report();
  end
endmodule
